// [hdl/flr_readout.sv]
// Operation
// - slots 79 to 237 of the read carry cyclical loop data decoded from the stored pointer.
// - slot 79 carries the loop entry whose index equals the stored pointer position, or 57 for a pointer above 57.
// - each later cyclical byte carries the entry one index lower than the one before.
// - the loop map holds exactly 58 byte entries, 0 to 57, walked cyclically.
// - each channel takes 12 indices from 2, 22, 34 and 46 in the fixed field order.
// - indices 14 to 21 carry input voltage, input status, a zero byte, input current, power.
// - indices 0 and 1 carry the second temperature, low byte then high byte.
// - slots 1 to 6 carry the 41-bit shared time stamp little-endian, lsb of 200 us.
// - with pointer 8 the walk yields channel 0 temp status, temp high, then temp low.
// - a 79-byte preamble precedes the loop data, ending with the channel status bytes.
// - slot numbers are data byte numbers counted from 1, less one.
`timescale 1ns/1ns
module flr_readout (
    input wire logic i_clk, // 10 MHz clock
    input wire logic i_rstn, // async reset, active low
    input wire logic i_start, // pulse: begin a block read
    input wire logic i_next, // pulse: host took the current byte
    input wire logic [7:0] i_pointer, // stored fault-log pointer position
    input wire logic [40:0] i_shared_time_stamp, // captured shared time
    input wire logic [575:0] i_peak_bytes, // preamble slots 7..78, slot 7 in low byte
    input wire logic [15:0] i_temp2, // second temperature reading
    input wire logic [15:0] i_vin, // input voltage
    input wire logic [7:0] i_input_status, // input status
    input wire logic [15:0] i_iin, // input current
    input wire logic [15:0] i_pin, // input power
    input wire logic [3:0][15:0] i_vout, // per-channel voltage
    input wire logic [3:0][7:0] i_vout_status, // per-channel voltage status
    input wire logic [3:0][7:0] i_vendor_status, // per-channel vendor status
    input wire logic [3:0][15:0] i_temp1, // per-channel temperature
    input wire logic [3:0][7:0] i_temp_status, // per-channel temperature status
    input wire logic [3:0][7:0] i_iout_status, // per-channel current status
    input wire logic [3:0][15:0] i_iout, // per-channel current
    input wire logic [3:0][15:0] i_pout, // per-channel power
    output logic o_valid, // byte on o_byte is valid
    output logic [7:0] o_byte, // current data byte
    output logic [7:0] o_slot, // slot of o_byte
    output logic o_last // o_byte is slot 254
);
    // reset release
    logic rst_meta_n;
    logic rst_n;

    // control group
    logic active;
    logic [7:0] slot;
    logic [5:0] pos;
    logic last;
    logic next_active;
    logic [7:0] next_slot;
    logic [5:0] next_pos;
    logic next_last;
    logic [5:0] start_pos;
    logic in_loop;

    // data group
    logic [7:0] byte_q;
    logic [7:0] next_byte;

    // release on a clock edge so no flop leaves reset a cycle apart from another
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // one channel's 12 fields in loop order
    function automatic logic [7:0] chan_byte(input logic [1:0] ch, input logic [3:0] off);
        logic [7:0] b;
        b = flr_pkg::RESET_BYTE;
        unique case (off)
            flr_pkg::FLD_VOUT_LO: b = i_vout[ch][7:0];
            flr_pkg::FLD_VOUT_HI: b = i_vout[ch][15:8];
            flr_pkg::FLD_VOUT_STAT: b = i_vout_status[ch];
            flr_pkg::FLD_VENDOR_STAT: b = i_vendor_status[ch];
            flr_pkg::FLD_TEMP_LO: b = i_temp1[ch][7:0];
            flr_pkg::FLD_TEMP_HI: b = i_temp1[ch][15:8];
            flr_pkg::FLD_TEMP_STAT: b = i_temp_status[ch];
            flr_pkg::FLD_IOUT_STAT: b = i_iout_status[ch];
            flr_pkg::FLD_IOUT_LO: b = i_iout[ch][7:0];
            flr_pkg::FLD_IOUT_HI: b = i_iout[ch][15:8];
            flr_pkg::FLD_POUT_LO: b = i_pout[ch][7:0];
            // offsets above 11 never occur, every caller stays inside its channel
            default: b = i_pout[ch][15:8];
        endcase
        return b;
    endfunction : chan_byte

    // map: 0-1 second temp, 2-13 ch0, 14-21 input, 22-57 ch1 to ch3
    function automatic logic [7:0] loop_byte(input logic [5:0] p);
        logic [7:0] b;
        b = flr_pkg::RESET_BYTE;
        if (p <= flr_pkg::POS_TEMP2_HI) begin
            b = p[0] ? i_temp2[15:8] : i_temp2[7:0];
        end else if (p < flr_pkg::POS_INPUT) begin
            b = chan_byte(2'd0, 4'(p - flr_pkg::POS_CH0));
        end else if (p < flr_pkg::POS_CH1) begin
            unique case (3'(p - flr_pkg::POS_INPUT))
                flr_pkg::IN_VIN_LO: b = i_vin[7:0];
                flr_pkg::IN_VIN_HI: b = i_vin[15:8];
                flr_pkg::IN_STATUS: b = i_input_status;
                // fixed zero entry keeps the map spacing uniform
                flr_pkg::IN_ZERO: b = flr_pkg::LOOP_ZERO_BYTE;
                flr_pkg::IN_IIN_LO: b = i_iin[7:0];
                flr_pkg::IN_IIN_HI: b = i_iin[15:8];
                flr_pkg::IN_PIN_LO: b = i_pin[7:0];
                flr_pkg::IN_PIN_HI: b = i_pin[15:8];
            endcase
        end else if (p < flr_pkg::POS_CH2) begin
            b = chan_byte(2'd1, 4'(p - flr_pkg::POS_CH1));
        end else if (p < flr_pkg::POS_CH3) begin
            b = chan_byte(2'd2, 4'(p - flr_pkg::POS_CH2));
        end else begin
            // the start clamp keeps p at or below 57, so this is channel 3 only
            b = chan_byte(2'd3, 4'(p - flr_pkg::POS_CH3));
        end
        return b;
    endfunction : loop_byte

    // read layout by slot:
    //   0        pointer position
    //   1..6     time stamp, low byte first
    //   7..78    peak and status preamble, as supplied
    //   79..237  loop map walked downward from the pointer
    //   238..254 reserved, zero
    function automatic logic [7:0] slot_byte(input logic [7:0] s, input logic [5:0] p);
        logic [7:0] b;
        logic [47:0] ts;
        logic [2:0] tsel;
        logic [6:0] psel;
        b = flr_pkg::RESET_BYTE;
        // bits 47:41 pad the top time byte with zeros
        ts = {7'h00, i_shared_time_stamp};
        tsel = 3'(s - flr_pkg::SLOT_TIME_FIRST);
        psel = 7'(s - flr_pkg::SLOT_PEAK_FIRST);
        if (s == flr_pkg::SLOT_POINTER) begin
            b = i_pointer;
        end else if (s <= flr_pkg::SLOT_TIME_LAST) begin
            b = ts[{tsel, 3'h0} +: 8];
        end else if (s < flr_pkg::SLOT_LOOP_FIRST) begin
            b = i_peak_bytes[{psel, 3'h0} +: 8];
        end else if (s <= flr_pkg::SLOT_LOOP_LAST) begin
            b = loop_byte(p);
        end
        return b;
    endfunction : slot_byte

    // out-of-map pointer clamps to the top rather than reading past the map
    assign start_pos = (i_pointer > 8'(flr_pkg::LOOP_TOP)) ? flr_pkg::LOOP_TOP
                                                          : i_pointer[5:0];
    // pos only steps while another loop byte follows
    assign in_loop = (slot >= flr_pkg::SLOT_LOOP_FIRST) && (slot < flr_pkg::SLOT_LOOP_LAST);

    // control group: which slot and loop position the read stands at
    always_comb begin
        next_active = active;
        next_slot = slot;
        next_pos = pos;
        if (i_start) begin
            // a start during an open read restarts it, next is ignored
            next_active = 1'b1;
            next_slot = flr_pkg::SLOT_POINTER;
            next_pos = start_pos;
        end else if (active && i_next) begin
            // slot holds at 254 after the last byte, valid and last drop and the byte reads zero
            if (slot == flr_pkg::SLOT_LAST) begin
                next_active = 1'b0;
            end else begin
                next_slot = slot + 8'h01;
            end
            if (in_loop) begin
                if (pos == flr_pkg::POS_BOTTOM) begin
                    next_pos = flr_pkg::LOOP_TOP;
                end else begin
                    next_pos = pos - 6'h01;
                end
            end
        end
        next_last = next_active && (next_slot == flr_pkg::SLOT_LAST);
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
            slot <= flr_pkg::SLOT_POINTER;
            pos <= flr_pkg::POS_BOTTOM;
            last <= 1'b0;
        end else begin
            active <= next_active;
            slot <= next_slot;
            pos <= next_pos;
            last <= next_last;
        end
    end

    // data group: inputs are re-read every cycle, so they must not move during a read
    always_comb begin
        // idle reads as zero
        next_byte = flr_pkg::RESET_BYTE;
        if (next_active) begin
            next_byte = slot_byte(next_slot, next_pos);
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_q <= flr_pkg::RESET_BYTE;
        end else begin
            byte_q <= next_byte;
        end
    end

    // ports are the registers themselves, no logic after the flops
    assign o_valid = active;
    assign o_byte = byte_q;
    assign o_slot = slot;
    assign o_last = last;
endmodule : flr_readout

// [hdl/flr_pkg.sv]
package flr_pkg;
    localparam logic [7:0] SLOT_POINTER = 8'h00;
    localparam logic [7:0] SLOT_TIME_FIRST = 8'h01;
    localparam logic [7:0] SLOT_TIME_LAST = 8'h06;
    localparam logic [7:0] SLOT_PEAK_FIRST = 8'h07;
    localparam logic [7:0] SLOT_LOOP_FIRST = 8'h4f;
    localparam logic [7:0] SLOT_LOOP_LAST = 8'hed;
    localparam logic [7:0] SLOT_LAST = 8'hfe;
    localparam int PEAK_BYTES = 72;
    localparam int TIME_BITS = 41;
    localparam int TIME_LSB_US = 200;
    localparam logic [5:0] LOOP_TOP = 6'h39;
    localparam logic [5:0] POS_TEMP2_HI = 6'h01;
    localparam logic [5:0] POS_CH0 = 6'h02;
    localparam logic [5:0] POS_INPUT = 6'h0e;
    localparam logic [5:0] POS_CH1 = 6'h16;
    localparam logic [5:0] POS_CH2 = 6'h22;
    localparam logic [5:0] POS_CH3 = 6'h2e;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] LOOP_ZERO_BYTE = 8'h00;
    localparam logic [5:0] POS_BOTTOM = 6'h00;
    // field offsets inside one channel's 12-entry run
    localparam logic [3:0] FLD_VOUT_LO = 4'h0;
    localparam logic [3:0] FLD_VOUT_HI = 4'h1;
    localparam logic [3:0] FLD_VOUT_STAT = 4'h2;
    localparam logic [3:0] FLD_VENDOR_STAT = 4'h3;
    localparam logic [3:0] FLD_TEMP_LO = 4'h4;
    localparam logic [3:0] FLD_TEMP_HI = 4'h5;
    localparam logic [3:0] FLD_TEMP_STAT = 4'h6;
    localparam logic [3:0] FLD_IOUT_STAT = 4'h7;
    localparam logic [3:0] FLD_IOUT_LO = 4'h8;
    localparam logic [3:0] FLD_IOUT_HI = 4'h9;
    localparam logic [3:0] FLD_POUT_LO = 4'ha;
    // field offsets inside the input run
    localparam logic [2:0] IN_VIN_LO = 3'h0;
    localparam logic [2:0] IN_VIN_HI = 3'h1;
    localparam logic [2:0] IN_STATUS = 3'h2;
    localparam logic [2:0] IN_ZERO = 3'h3;
    localparam logic [2:0] IN_IIN_LO = 3'h4;
    localparam logic [2:0] IN_IIN_HI = 3'h5;
    localparam logic [2:0] IN_PIN_LO = 3'h6;
    localparam logic [2:0] IN_PIN_HI = 3'h7;
endpackage : flr_pkg

// [verification/flr_readout_assertions.sv]
`timescale 1ns/1ns
module flr_readout_checker (
    input wire logic i_clk, // clock
    input wire logic i_rstn, // reset
    input wire logic i_start, // start
    input wire logic i_next, // advance
    input wire logic [7:0] i_pointer, // pointer
    input wire logic [15:0] i_temp2, // second temperature
    input wire logic [3:0][7:0] i_temp_status, // channel temperature status
    input wire logic [3:0][15:0] i_pout, // channel power
    input wire logic o_valid, // valid
    input wire logic [7:0] o_byte, // byte
    input wire logic [7:0] o_slot, // slot
    input wire logic o_last // last
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire adv = o_valid && i_next && !i_start;
    start_load_a: assert property (i_start |=> o_valid && o_slot == 8'h00
        && o_byte == $past(i_pointer))
        else $error("start load");
    slot_step_a: assert property (adv && !o_last |=> o_slot == $past(o_slot) + 8'h01)
        else $error("slot step");
    last_flag_a: assert property (o_valid |-> o_last == (o_slot == 8'hfe))
        else $error("last flag");
    read_end_a: assert property (adv && o_last |=> !o_valid && o_byte == 8'h00)
        else $error("read end");
    idle_hold_a: assert property (!o_valid && !i_start |=> !o_valid)
        else $error("idle");
    byte_hold_a: assert property (o_valid && !i_next && !i_start
        |=> $stable({o_byte, o_slot}))
        else $error("hold");
    time_top_a: assert property (o_valid && o_slot == 8'h06 |-> o_byte[7:1] == 7'h00)
        else $error("time top");
    reserved_zero_a: assert property (o_valid && o_slot > 8'hed |-> o_byte == 8'h00)
        else $error("reserved");
    ptr_zero_a: assert property (o_valid && o_slot == 8'h4f && i_pointer == 8'h00
        |-> o_byte == i_temp2[7:0])
        else $error("pointer zero entry");
    map_wrap_a: assert property (o_valid && o_slot == 8'h50 && i_pointer == 8'h00
        |-> o_byte == i_pout[3][15:8])
        else $error("map wrap");
    ptr_eight_a: assert property (o_valid && o_slot == 8'h4f && i_pointer == 8'h08
        |-> o_byte == i_temp_status[0])
        else $error("pointer eight entry");
    loop_entry_a: assert property (adv && o_slot == 8'h4e |=> o_slot == 8'h4f)
        else $error("loop entry");
    cover property (adv && o_last);
    cover property (i_start && o_valid);
    cover property (adv && o_slot == 8'h4e);
endmodule : flr_readout_checker
bind flr_readout flr_readout_checker u_flr_readout_checker (.*);

// [verification/flr_host.sv]
`timescale 1ns/1ns
module flr_host (
    input wire logic i_clk, // clock
    output logic o_start, // begin read
    output logic o_next // byte taken
);
    initial begin
        o_start = 1'b0;
        o_next = 1'b0;
    end
    // one call per falling edge, a stall is just n low
    task automatic step(input logic s, input logic n);
        @(negedge i_clk);
        o_start = s;
        o_next = n;
    endtask : step
endmodule : flr_host

// [verification/test_flr_readout.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("BAD %0t mismatch got %h want %h", $time, (a), (e)); end end
module test_flr_readout;
    logic i_clk, i_rstn, i_start, i_next, o_valid, o_last, adv, rs, rs_done;
    logic [17:0] obs, want;
    logic [7:0] i_pointer, i_input_status, o_byte, o_slot;
    logic [40:0] i_shared_time_stamp;
    logic [575:0] i_peak_bytes;
    logic [15:0] i_temp2, i_vin, i_iin, i_pin;
    logic [3:0][15:0] i_vout, i_temp1, i_iout, i_pout;
    logic [3:0][7:0] i_vout_status, i_vendor_status, i_temp_status, i_iout_status;
    logic [7:0] ptrs [5] = '{8'h08, 8'h0d, 8'h00, 8'h39, 8'h3f};
    int failures, n_checks, s, k;
    flr_readout u_flr_readout (.*);
    flr_host u_flr_host (.i_clk(i_clk), .o_start(i_start), .o_next(i_next));
    function automatic logic [7:0] exp_byte(int n);
        logic [57:0][7:0] m;
        logic [47:0] t;
        int b, p;
        t = {7'h00, i_shared_time_stamp};
        m = '0;
        m[1:0] = i_temp2;
        m[15:14] = i_vin;
        m[16] = i_input_status;
        m[19:18] = i_iin;
        m[21:20] = i_pin;
        for (int c = 0; c < 4; c++) begin
            b = (c == 0) ? 2 : 10 + 12 * c;
            m[b+:2] = i_vout[c];
            m[b+2] = i_vout_status[c];
            m[b+3] = i_vendor_status[c];
            m[b+4+:2] = i_temp1[c];
            m[b+6] = i_temp_status[c];
            m[b+7] = i_iout_status[c];
            m[b+8+:2] = i_iout[c];
            m[b+10+:2] = i_pout[c];
        end
        p = (i_pointer > 8'h39 ? 57 : int'(i_pointer)) - (n - 79);
        p = (p % 58 + 58) % 58;
        if (n == 0) return i_pointer;
        if (n < 7) return t[8*(n-1)+:8];
        if (n < 79) return i_peak_bytes[8*(n-7)+:8];
        if (n < 238) return m[p];
        return 8'h00;
    endfunction : exp_byte
    task automatic fill();
        i_pointer = (k < 5) ? ptrs[k] : 8'($urandom_range(57));
        i_shared_time_stamp = 41'({$urandom, $urandom});
        for (int i = 0; i < 18; i++) i_peak_bytes[32*i+:32] = $urandom;
        {i_temp2, i_vin, i_iin, i_pin} = {$urandom, $urandom};
        {i_vout, i_temp1} = {$urandom, $urandom, $urandom, $urandom};
        {i_iout, i_pout} = {$urandom, $urandom, $urandom, $urandom};
        {i_vout_status, i_vendor_status} = {$urandom, $urandom};
        {i_temp_status, i_iout_status, i_input_status} = {$urandom, $urandom, 8'($urandom)};
    endtask : fill
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        #1000000;
        failures++;
        final_report();
    end
    initial begin
        i_rstn = 1'b0;
        void'($urandom(32'hc3b1));
        fill();
        repeat (10) @(negedge i_clk);
        i_rstn = 1'b1;
        repeat (3) @(negedge i_clk);
        `CHK({o_valid, o_last, o_slot, o_byte}, 18'h00000)
        for (k = 0; k < 6; k++) begin
            fill();
            u_flr_host.step(1'b1, 1'b0);
            s = 0;
            rs_done = 1'b0;
            while (s < 255) begin
                adv = 1'($urandom % 4 != 0);
                // one mid-read restart at slot 120 of the second read, with next as random as on any other step
                rs = (k == 1 && s == 120 && !rs_done);
                rs_done = rs_done | rs;
                u_flr_host.step(rs, adv);
                obs = {o_valid, o_last, o_slot, o_byte};
                want = {1'b1, s == 254, 8'(s), exp_byte(s)};
                `CHK(obs, want)
                s = rs ? 0 : s + int'(adv);
            end
            u_flr_host.step(1'b0, 1'b0);
            `CHK({o_valid, o_last, o_byte}, 10'h000)
        end
        final_report();
    end
endmodule : test_flr_readout
